// ==== dv/blt_ctrl_tb.sv ====
// self-checking bench for the block-transfer control register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        ref_clk_i;
  logic        rst_n_i;
  logic [15:0] addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  logic        busy_o;
  logic [20:0] src_addr_o;
  logic [20:0] dst_addr_o;
  int          err_total;
  int          comparisons;
  logic [31:0] rv;

  blt_ctrl u_blt_ctrl (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .busy_o(busy_o), .src_addr_o(src_addr_o),
    .dst_addr_o(dst_addr_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_map;
    logic [15:0] ofs[7];
    ofs = '{16'h8000, 16'h8004, 16'h800C, 16'h8010, 16'h8014, 16'h8018, 16'h801C};
    foreach (ofs[i]) begin
      reg_rd(ofs[i], rv);
      check("reset value", rv, 32'h00000000);
    end
    reg_wr(16'h8000, 32'hFFFFFFFE);
    reg_rd(16'h8000, rv);
    check("ctrl unused bits", rv, 32'h00070000);
    reg_wr(16'h800C, 32'hFFFFFFFF);
    reg_rd(16'h800C, rv);
    check("src base width", rv, 32'h001FFFFF);
    reg_wr(16'h8008, 32'hFFFFFFFF);
    reg_rd(16'h8008, rv);
    check("unmapped read", rv, 32'h00000000);
    $display("test map done");
  endtask

  task automatic run_blit(input logic [31:0] ctrl, input logic [20:0] sb, input logic [20:0] db,
                          input logic [20:0] ro, input int w, input int h);
    logic [20:0] es;
    logic [20:0] ed;
    int          st;
    reg_wr(16'h800C, {11'h000, sb});
    reg_wr(16'h8010, {11'h000, db});
    reg_wr(16'h8014, {11'h000, ro});
    reg_wr(16'h8018, 32'(w));
    reg_wr(16'h801C, 32'(h));
    reg_wr(16'h8000, ctrl | 32'h00000001);
    st = ctrl[18] ? 2 : 1;
    for (int r = 0; r < h; r++) begin
      for (int c = 0; c < w; c++) begin
        #1;
        es = ctrl[16] ? 21'(sb + (r * w + c) * st) : 21'(sb + r * ro + c * st);
        ed = ctrl[17] ? 21'(db + (r * w + c) * st) : 21'(db + r * ro + c * st);
        check("busy during run", {31'h0, busy_o}, 32'h1);
        check("src pointer", {11'h0, src_addr_o}, {11'h0, es});
        check("dst pointer", {11'h0, dst_addr_o}, {11'h0, ed});
        @(posedge ref_clk_i);
      end
    end
    #1 check("busy after run", {31'h0, busy_o}, 32'h0);
    reg_rd(16'h8000, rv);
    check("ctrl readback", rv, ctrl & 32'h00070000);
    $display("test blit %h done", ctrl);
  endtask

  task automatic t_status;
    int n;
    reg_wr(16'h8018, 32'h00000008);
    reg_wr(16'h801C, 32'h00000001);
    reg_wr(16'h8000, 32'h00000001);
    reg_rd(16'h8004, rv);
    check("status busy", rv, 32'h00000001);
    // a second start while busy, never a zero write while busy
    reg_wr(16'h8000, 32'h00000001);
    #1 check("restart ignored", {31'h0, busy_o}, 32'h1);
    n = 0;
    while (busy_o === 1'b1 && n < 20) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    // 8 busy cycles in all, 4 already spent on the bus
    check("busy run length", 32'(n), 32'h00000004);
    reg_wr(16'h8000, 32'h00000000);
    reg_rd(16'h8004, rv);
    check("status idle", rv, 32'h00000000);
    @(posedge ref_clk_i);
    #1 check("rdata back to zero", rdata_o, 32'h00000000);
    $display("test status done");
  endtask

  // ----------------------------------------
  // verdict and sequence
  // ----------------------------------------
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #(50 * 3000);
    err_total++;
    final_report();
  end

  initial begin
    err_total   = 0;
    comparisons = 0;
    rst_n_i     = 1'b0;
    addr_i      = 16'h0000;
    wdata_i     = 32'h00000000;
    wr_i        = 1'b0;
    rd_i        = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_map();
    run_blit(32'h00020000, 21'h000010, 21'h000100, 21'h000040, 2, 2);
    run_blit(32'h00050000, 21'h000020, 21'h000200, 21'h000040, 2, 2);
    run_blit(32'h00000000, 21'h000300, 21'h000400, 21'h000010, 3, 2);
    t_status();
    final_report();
  end
endmodule
`default_nettype wire

// ==== hw/blt_ctrl.sv ====
// block-transfer control register bank with address walker
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "blt_defs.svh"

module blt_ctrl (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             busy_o,
  output logic      [20:0] src_addr_o,
  output logic      [20:0] dst_addr_o
);
  import blt_pkg::*;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic blt_ptr_t step_of(input logic depth);
    step_of = depth ? `BLT_STEP16 : `BLT_STEP8;
  endfunction

  logic       wr_ctrl_w;
  logic       start_w;
  blt_state_t state_r;
  blt_state_t state_nxt;
  logic       depth_r;
  logic       slin_r;
  logic       dlin_r;
  blt_ptr_t   src_base_r;
  blt_ptr_t   dst_base_r;
  blt_ptr_t   row_ofs_r;
  blt_cnt_t   wid_r;
  blt_cnt_t   hgt_r;
  blt_cnt_t   col_r;
  blt_cnt_t   line_r;
  blt_cnt_t   col_nxt;
  blt_cnt_t   line_nxt;
  logic       run_w;
  logic       row_end_w;
  logic       last_w;
  blt_ptr_t   step_w;
  logic [31:0] rd_mux_w;
  blt_ptr_t   src_row_w;
  blt_ptr_t   dst_row_w;

  assign wr_ctrl_w = wr_i && hit(addr_i, `BLT_OFS_CTRL);
  assign start_w   = wr_ctrl_w && wdata_i[`BLT_BIT_EN] && (state_r == BLT_IDLE);
  assign run_w     = (state_r == BLT_RUN);
  assign row_end_w = run_w && (col_r == wid_r - `BLT_ONE_CNT);
  assign last_w    = row_end_w && (line_r == hgt_r - `BLT_ONE_CNT);
  assign step_w    = step_of(depth_r);
  assign col_nxt   = start_w ? `BLT_RST_CNT : (row_end_w ? `BLT_RST_CNT : (run_w ? col_r + `BLT_ONE_CNT : col_r));
  assign line_nxt  = start_w ? `BLT_RST_CNT : (row_end_w ? line_r + `BLT_ONE_CNT : line_r);
  assign state_nxt = start_w ? BLT_RUN : (last_w ? BLT_IDLE : state_r);

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  // enable bit is write only and always reads back zero
  assign rd_mux_w =
    hit(addr_i, `BLT_OFS_CTRL) ? {13'h0000, depth_r, dlin_r, slin_r, 16'h0000} :
    hit(addr_i, `BLT_OFS_STAT) ? {31'h00000000, run_w} :
    hit(addr_i, `BLT_OFS_SRC)  ? {11'h000, src_base_r} :
    hit(addr_i, `BLT_OFS_DST)  ? {11'h000, dst_base_r} :
    hit(addr_i, `BLT_OFS_ROW)  ? {11'h000, row_ofs_r} :
    hit(addr_i, `BLT_OFS_WID)  ? {22'h000000, wid_r} :
    hit(addr_i, `BLT_OFS_HGT)  ? {22'h000000, hgt_r} : `BLT_RST_WORD;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      depth_r    <= 1'b0;
      slin_r     <= 1'b0;
      dlin_r     <= 1'b0;
      src_base_r <= `BLT_RST_PTR;
      dst_base_r <= `BLT_RST_PTR;
      row_ofs_r  <= `BLT_RST_PTR;
      wid_r      <= `BLT_RST_CNT;
      hgt_r      <= `BLT_RST_CNT;
      rdata_o    <= `BLT_RST_WORD;
    end else begin
      if (wr_ctrl_w) begin
        depth_r <= wdata_i[`BLT_BIT_DEPTH];
        dlin_r  <= wdata_i[`BLT_BIT_DLIN];
        slin_r  <= wdata_i[`BLT_BIT_SLIN];
      end
      if (wr_i && hit(addr_i, `BLT_OFS_SRC)) src_base_r <= wdata_i[20:0];
      if (wr_i && hit(addr_i, `BLT_OFS_DST)) dst_base_r <= wdata_i[20:0];
      if (wr_i && hit(addr_i, `BLT_OFS_ROW)) row_ofs_r  <= wdata_i[20:0];
      if (wr_i && hit(addr_i, `BLT_OFS_WID)) wid_r      <= wdata_i[9:0];
      if (wr_i && hit(addr_i, `BLT_OFS_HGT)) hgt_r      <= wdata_i[9:0];
      rdata_o <= rd_i ? rd_mux_w : `BLT_RST_WORD;
    end
  end

  // ---------------------------------------------------------------
  // walker
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= BLT_IDLE;
      busy_o  <= 1'b0;
      col_r   <= `BLT_RST_CNT;
      line_r  <= `BLT_RST_CNT;
    end else begin
      state_r <= state_nxt;
      busy_o  <= (state_nxt == BLT_RUN);
      col_r   <= col_nxt;
      line_r  <= line_nxt;
    end
  end

  blt_ptr u_src (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .load_i    (start_w),
    .base_i    (src_base_r),
    .adv_i     (run_w),
    .row_end_i (row_end_w),
    .linear_i  (slin_r),
    .step_i    (step_w),
    .offset_i  (row_ofs_r),
    .ptr_o     (src_addr_o),
    .row_o     (src_row_w)
  );

  blt_ptr u_dst (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .load_i    (start_w),
    .base_i    (dst_base_r),
    .adv_i     (run_w),
    .row_end_i (row_end_w),
    .linear_i  (dlin_r),
    .step_i    (step_w),
    .offset_i  (row_ofs_r),
    .ptr_o     (dst_addr_o),
    .row_o     (dst_row_w)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_start;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `BLT_OFS_CTRL && wdata_i[`BLT_BIT_EN] && !busy_o && !run_w)
      |=> busy_o && src_addr_o == $past(src_base_r) && dst_addr_o == $past(dst_base_r);
  endproperty
  a_start: assert property (p_start) else $error("start write did not begin transfer");

  property p_ctrl_rd;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == `BLT_OFS_CTRL) |=> rdata_o[15:0] == 16'h0000 && rdata_o[31:19] == 13'h0000
      && rdata_o[`BLT_BIT_DEPTH] == $past(depth_r) && rdata_o[`BLT_BIT_DLIN] == $past(dlin_r)
      && rdata_o[`BLT_BIT_SLIN] == $past(slin_r);
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");

  property p_stat_rd;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == `BLT_OFS_STAT) |=> rdata_o == {31'h00000000, $past(busy_o)};
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status busy bit wrong");

  property p_unmapped;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i[15] == 1'b0) |=> rdata_o == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("read outside bank not zero");

  property p_step8;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (run_w && !row_end_w && !depth_r) |=> src_addr_o == $past(src_addr_o) + `BLT_STEP8;
  endproperty
  a_step8: assert property (p_step8) else $error("8 bpp step wrong");

  property p_step16;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (run_w && !row_end_w && depth_r) |=> dst_addr_o == $past(dst_addr_o) + `BLT_STEP16;
  endproperty
  a_step16: assert property (p_step16) else $error("16 bpp step wrong");

  property p_dst_lin;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (row_end_w && !last_w && dlin_r) |=> dst_addr_o == $past(dst_addr_o) + $past(step_w);
  endproperty
  a_dst_lin: assert property (p_dst_lin) else $error("linear destination not packed");

  property p_dst_rect;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (row_end_w && !last_w && !dlin_r) |=> dst_addr_o == $past(dst_row_w) + $past(row_ofs_r);
  endproperty
  a_dst_rect: assert property (p_dst_rect) else $error("rectangular destination wrap wrong");

  property p_src_rect;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (row_end_w && !last_w && !slin_r) |=> src_addr_o == $past(src_row_w) + $past(row_ofs_r);
  endproperty
  a_src_rect: assert property (p_src_rect) else $error("rectangular source wrap wrong");

  property p_src_lin;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (row_end_w && !last_w && slin_r) |=> src_addr_o == $past(src_addr_o) + $past(step_w);
  endproperty
  a_src_lin: assert property (p_src_lin) else $error("linear source not continued");

  property p_done;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    last_w |=> !busy_o;
  endproperty
  a_done: assert property (p_done) else $error("busy stayed after last pixel");
endmodule

`default_nettype wire

// ==== hw/blt_defs.svh ====
// constants for the block-transfer control register bank
`ifndef BLT_DEFS_SVH
`define BLT_DEFS_SVH

`define BLT_AW        16
`define BLT_PW        21
`define BLT_CW        10
`define BLT_OFS_CTRL  16'h8000
`define BLT_OFS_STAT  16'h8004
`define BLT_OFS_SRC   16'h800C
`define BLT_OFS_DST   16'h8010
`define BLT_OFS_ROW   16'h8014
`define BLT_OFS_WID   16'h8018
`define BLT_OFS_HGT   16'h801C
`define BLT_BIT_EN    0
`define BLT_BIT_SLIN  16
`define BLT_BIT_DLIN  17
`define BLT_BIT_DEPTH 18
`define BLT_BIT_BUSY  0
`define BLT_STEP8     21'h000001
`define BLT_STEP16    21'h000002
`define BLT_RST_WORD  32'h00000000
`define BLT_RST_PTR   21'h000000
`define BLT_RST_CNT   10'h000
`define BLT_ONE_CNT   10'h001

`endif

// ==== hw/blt_pkg.sv ====
// types shared by the block-transfer engine files
package blt_pkg;
  typedef enum logic {BLT_IDLE, BLT_RUN} blt_state_t;
  typedef logic [20:0] blt_ptr_t;
  typedef logic [9:0]  blt_cnt_t;
endpackage

// ==== hw/blt_ptr.sv ====
// address pointer with row-end update in rectangular or linear mode
`timescale 1ns/10ps
`default_nettype none
`include "blt_defs.svh"

module blt_ptr (
  input  wire logic            ref_clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            load_i,
  input  wire blt_pkg::blt_ptr_t base_i,
  input  wire logic            adv_i,
  input  wire logic            row_end_i,
  input  wire logic            linear_i,
  input  wire blt_pkg::blt_ptr_t step_i,
  input  wire blt_pkg::blt_ptr_t offset_i,
  output logic                 [20:0] ptr_o,
  output logic                 [20:0] row_o
);
  import blt_pkg::*;

  blt_ptr_t ptr_r;
  blt_ptr_t row_r;
  blt_ptr_t ptr_nxt;
  blt_ptr_t row_nxt;
  blt_ptr_t seq_w;
  blt_ptr_t wrap_w;

  assign seq_w   = ptr_r + step_i;
  // linear packs rows back to back, rectangular jumps by the row offset
  assign wrap_w  = linear_i ? seq_w : (row_r + offset_i);
  assign ptr_nxt = load_i ? base_i : (adv_i ? (row_end_i ? wrap_w : seq_w) : ptr_r);
  assign row_nxt = load_i ? base_i : ((adv_i && row_end_i) ? wrap_w : row_r);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_r <= `BLT_RST_PTR;
      row_r <= `BLT_RST_PTR;
    end else begin
      ptr_r <= ptr_nxt;
      row_r <= row_nxt;
    end
  end

  assign ptr_o = ptr_r;
  assign row_o = row_r;
endmodule

`default_nettype wire
